// ---- shared/cdtrt_pkg.sv ----
// shared constants and carriers for the countdown timer and rate trim block
package cdtrt_pkg;

   // core clock and time base
   localparam int unsigned CLK_HZ        = 100_000_000;    // core clock rate
   localparam int unsigned CLK_PERIOD_NS = 10;             // core clock period
   localparam int unsigned XTAL_HZ       = 32_768;         // emulated crystal rate
   localparam int unsigned ACC_W         = 28;             // phase accumulator width

   // interrupt auto-return widths in repeat mode, rounded down to whole cycles
   localparam int unsigned PULSE_FAST_NS  = 122_000;       // 0.122 ms, 4096 Hz source
   localparam int unsigned PULSE_SLOW_NS  = 7_810_000;     // 7.81 ms, other sources
   localparam int unsigned PULSE_FAST_CYC = PULSE_FAST_NS / CLK_PERIOD_NS;
   localparam int unsigned PULSE_SLOW_CYC = PULSE_SLOW_NS / CLK_PERIOD_NS;

   // half-minute round request hold time
   localparam int unsigned ADJ_HOLD_NS  = 183_000;         // within the 244 us auto clear
   localparam int unsigned ADJ_HOLD_CYC = ADJ_HOLD_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W        = 20;              // width of the long counters

   // register addresses
   localparam logic [3:0] ADDR_TRIM_LO    = 4'h0;          // bank 2
   localparam logic [3:0] ADDR_TRIM_HI    = 4'h1;          // bank 2
   localparam logic [3:0] ADDR_PRESET_LO  = 4'h4;          // bank 2
   localparam logic [3:0] ADDR_PRESET_HI  = 4'h5;          // bank 2
   localparam logic [3:0] ADDR_LIVE_LO    = 4'h6;          // bank 2
   localparam logic [3:0] ADDR_LIVE_HI    = 4'h7;          // bank 2
   localparam logic [3:0] ADDR_TIMER_CTRL = 4'h8;          // bank 2
   localparam logic [3:0] ADDR_CS1_CTRL   = 4'hB;          // bank 1
   localparam logic [3:0] ADDR_CTRL_E     = 4'hE;          // every bank
   localparam logic [3:0] ADDR_CTRL_F     = 4'hF;          // every bank

   // bank numbers after decode
   localparam logic [1:0] BANK_0 = 2'h0;
   localparam logic [1:0] BANK_1 = 2'h1;
   localparam logic [1:0] BANK_2 = 2'h2;

   // field positions
   localparam int unsigned F_BANK_LO  = 2;                 // control F bank select 3:2
   localparam int unsigned F_HALT     = 1;
   localparam int unsigned F_ADJ      = 0;
   localparam int unsigned E_TEST     = 3;
   localparam int unsigned E_TEMP     = 2;
   localparam int unsigned E_IRQ_EN   = 1;
   localparam int unsigned E_FLAG     = 0;
   localparam int unsigned T_RUN      = 3;
   localparam int unsigned T_REPEAT   = 2;
   localparam int unsigned T_SEL_LO   = 0;                 // source select 1:0
   localparam int unsigned TH_ENABLE  = 3;
   localparam int unsigned C_TEMP     = 3;
   localparam int unsigned C_BYPASS   = 2;

   // reset values
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [7:0] RST_BYTE   = 8'h00;

   // sub-second divider
   localparam logic [15:0] SECOND_LEN = 16'h8000;          // crystal counts per second
   localparam logic [15:0] MASK_4096  = 16'h0007;
   localparam logic [15:0] MASK_64    = 16'h01FF;
   localparam logic [3:0]  TRIM_SLOT  = 4'h9;              // trimmed second of each ten

   // countdown source select codes
   typedef enum logic [1:0] {
      CDTRT_SRC_4096 = 2'h0,
      CDTRT_SRC_64   = 2'h1,
      CDTRT_SRC_SEC  = 2'h2,
      CDTRT_SRC_MIN  = 2'h3
   } cdtrt_src_e;

   // parallel bus pins
   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [3:0] addr;
      logic [3:0] data;
   } cdtrt_bus_s;

   // time base enables
   typedef struct packed {
      logic tick_4096;
      logic tick_64;
      logic tick_sec;
   } cdtrt_ticks_s;

endpackage

// ---- core/cdtrt_timebase.sv ----
`timescale 1ns/1ps
// crystal emulation, sub-second divider and rate trim
module cdtrt_timebase #(
   parameter int unsigned CLK_HZ = cdtrt_pkg::CLK_HZ
) (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // control
   input  wire logic                   halt_in,
   input  wire logic                   trim_active_in,
   input  wire logic [6:0]             trim_value_in,
   // enables
   output cdtrt_pkg::cdtrt_ticks_s     ticks_out
);

   typedef struct packed {
      logic [cdtrt_pkg::ACC_W-1:0] acc;   // phase of the 32768 Hz rate
      logic [15:0]                 sub;   // crystal counts within the second
      logic [3:0]                  tens;  // second within the ten-second frame
      cdtrt_pkg::cdtrt_ticks_s     ticks; // one-cycle enables
   } cdtrt_tb_state_s;

   cdtrt_tb_state_s s;       // registered state
   cdtrt_tb_state_s next_s;  // next state

   // next state
   always_comb begin
      logic [cdtrt_pkg::ACC_W-1:0] sum;
      logic [15:0]                 len;
      sum    = s.acc + cdtrt_pkg::ACC_W'(cdtrt_pkg::XTAL_HZ);
      len    = cdtrt_pkg::SECOND_LEN;
      next_s = s;
      next_s.ticks = '0;
      // one second in ten is shortened or lengthened by the signed trim code,
      // each crystal count being 1/327680 of ten seconds, about 3.05 ppm
      if (trim_active_in && s.tens == cdtrt_pkg::TRIM_SLOT) begin
         len = cdtrt_pkg::SECOND_LEN - {{9{trim_value_in[6]}}, trim_value_in}; // [RQ20] [RQ23] [RQ24]
      end
      if (halt_in) begin
         // halt clears the divider so the next second starts cleanly
         next_s.acc = '0;
         next_s.sub = '0;
      end else if (sum >= cdtrt_pkg::ACC_W'(CLK_HZ)) begin
         next_s.acc = sum - cdtrt_pkg::ACC_W'(CLK_HZ);
         next_s.ticks.tick_4096 = (s.sub & cdtrt_pkg::MASK_4096) == cdtrt_pkg::MASK_4096;
         next_s.ticks.tick_64   = (s.sub & cdtrt_pkg::MASK_64) == cdtrt_pkg::MASK_64;
         if (s.sub >= len - 16'h0001) begin
            next_s.sub = '0;
            next_s.ticks.tick_sec = 1'b1;
            next_s.tens = (s.tens == cdtrt_pkg::TRIM_SLOT) ? 4'h0 : s.tens + 4'h1;
         end else begin
            next_s.sub = s.sub + 16'h0001;
         end
      end else begin
         next_s.acc = sum;
      end
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign ticks_out = s.ticks;

endmodule

// ---- core/cdtrt_top.sv ----
//
// Function
// RQ1 - countdown flag sets at zero, only 0 clears
// RQ2 - run bit 1 counts, 0 holds count
// RQ3 - irq enable off: flag sets, pin untouched
// RQ4 - level mode: pin low until flag cleared
// RQ5 - repeat mode: short low pulse, flag stays
// RQ6 - pulse 0.122 ms at 4096 Hz, else 7.81 ms
// RQ7 - alarm and timer share the active-low pin
// RQ8 - level mode: zero clears run, count stays zero
// RQ9 - repeat mode: zero reloads preset, keeps counting
// RQ10 - live count nibbles readable, writes ignored
// RQ11 - preset write loads counter, preset is kept
// RQ12 - zero preset never raises a timer interrupt
// RQ13 - source select: 4096 Hz, 64 Hz, second, minute
// RQ14 - interval equals preset times source period
// RQ15 - interval may be short by one period
// RQ16 - counting starts at the write strobe's rising edge
// RQ17 - minute source may be off by a minute
// RQ18 - software expects one late step after stop
// RQ19 - without interrupts, software polls both flags
// RQ20 - enabled trim alters one second per ten
// RQ21 - trim needs enable and chip select or bypass
// RQ22 - software clears trim enable if unused
// RQ23 - trim code is two's complement 3.05 ppm steps
// RQ24 - trim range -195.20 to +192.15 ppm
// RQ25 - control registers E and F in every bank
// RQ26 - bank codes 0,1,2 and 3 maps to 1
//
`timescale 1ns/1ps
module cdtrt_top #(
   parameter int unsigned CLK_HZ         = cdtrt_pkg::CLK_HZ,
   parameter int unsigned PULSE_FAST_CYC = cdtrt_pkg::PULSE_FAST_CYC,
   parameter int unsigned PULSE_SLOW_CYC = cdtrt_pkg::PULSE_SLOW_CYC,
   parameter int unsigned ADJ_HOLD_CYC   = cdtrt_pkg::ADJ_HOLD_CYC
) (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // parallel register bus pins
   input  cdtrt_pkg::cdtrt_bus_s       bus_in,
   output logic [3:0]                  bus_data_out,
   output logic                        bus_data_oe_out,
   // chip select one pin and neighbouring clock logic
   input  wire logic                   chip_select_one_pin_in,
   input  wire logic                   alarm_irq_req_in,
   input  wire logic                   minute_tick_in,
   // interrupt pin, open drain
   output logic                        irq_n_out,
   output logic                        irq_oe_out,
   // towards the calendar
   output logic                        second_tick_out,
   output logic                        half_minute_round_out,
   output logic                        halt_out
);

   typedef struct packed {
      cdtrt_pkg::cdtrt_bus_s bus_s1;       // first synchroniser stage
      cdtrt_pkg::cdtrt_bus_s bus_s2;       // second synchroniser stage
      logic                  wr_n_prev;    // write strobe, one cycle older
      logic                  cs1_s1;       // chip select one, first stage
      logic                  cs1_s2;       // chip select one, second stage
      logic [3:0]            trim_lo;      // rate_trim_low
      logic [3:0]            trim_hi;      // rate_trim_high_enable
      logic [1:0]            cs1_ctrl;     // temp link and trim bypass
      logic [7:0]            preset;       // stored preset
      logic [7:0]            count;        // live down counter
      logic [3:0]            tctrl;        // run, repeat, source select
      logic                  test;         // stored only
      logic                  temp;         // stored only
      logic                  irq_enable;   // countdown_irq_enable
      logic                  flag;         // countdown_event_flag
      logic [1:0]            bank;         // bank select code
      logic                  halt;         // timekeeper halt
      logic                  adj;          // half-minute round pending
      logic [cdtrt_pkg::CNT_W-1:0] adj_cnt;   // round hold counter
      logic [cdtrt_pkg::CNT_W-1:0] pulse_cnt; // repeat pulse counter
      logic                  round_req;    // round request pulse
      logic                  sec_tick;     // second enable copy
      logic [3:0]            data_out;     // read data
      logic                  data_oe;      // read data drive
      logic                  irq_oe;       // pin pulled low
      logic                  irq_n;        // pin level when driven
   } cdtrt_state_s;

   cdtrt_state_s            s;       // registered state
   cdtrt_state_s            next_s;  // next state
   cdtrt_pkg::cdtrt_ticks_s ticks;   // time base enables
   logic                    trim_on; // trim allowed to act

   // trim acts only with its enable and either the pin or the bypass bit
   assign trim_on = s.trim_hi[cdtrt_pkg::TH_ENABLE]
                    & (s.cs1_s2 | s.cs1_ctrl[cdtrt_pkg::C_BYPASS - 2]); // [RQ21]

   // divider chain and rate trim
   cdtrt_timebase #(
      .CLK_HZ (CLK_HZ)
   ) u_timebase (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .halt_in        (s.halt),
      .trim_active_in (trim_on),
      .trim_value_in  ({s.trim_hi[2:0], s.trim_lo}),
      .ticks_out      (ticks)
   );

   // bank code 3 is an alias of bank 1
   function automatic logic [1:0] bank_of(input logic [1:0] code);
      logic [1:0] b;
      b = (code == 2'h3) ? cdtrt_pkg::BANK_1 : code; // [RQ26]
      return b;
   endfunction

   // next state
   always_comb begin
      logic       wr_evt;      // write taken this cycle
      logic       rd_act;      // read strobe active
      logic       src_tick;    // selected source enable
      logic       event_hit;   // counter reached zero
      logic [1:0] bank_eff;    // decoded bank
      logic [3:0] addr;        // synchronised address
      logic [3:0] d;           // synchronised write data
      logic [3:0] rdata;       // read mux result
      logic       timer_drive; // timer pulls the pin low
      next_s    = s;
      addr      = s.bus_s2.addr;
      d         = s.bus_s2.data;
      bank_eff  = bank_of(s.bank);
      event_hit = 1'b0;
      rdata     = 4'h0;

      // every bus pin goes through two flops before use
      next_s.bus_s1    = bus_in;
      next_s.bus_s2    = s.bus_s1;
      next_s.wr_n_prev = s.bus_s2.wr_n;
      next_s.cs1_s1    = chip_select_one_pin_in;
      next_s.cs1_s2    = s.cs1_s1;
      next_s.sec_tick  = ticks.tick_sec;
      next_s.round_req = 1'b0;

      // a write is taken on the rising edge of the write strobe
      wr_evt = s.bus_s2.wr_n & ~s.wr_n_prev & ~s.bus_s2.cs_n; // [RQ16]
      rd_act = ~s.bus_s2.cs_n & ~s.bus_s2.rd_n;

      // source select; minute steps follow the calendar carry, so a start
      // or stop may be off by up to a minute
      unique case (cdtrt_pkg::cdtrt_src_e'(s.tctrl[cdtrt_pkg::T_SEL_LO +: 2]))
         cdtrt_pkg::CDTRT_SRC_4096: src_tick = ticks.tick_4096;  // [RQ13]
         cdtrt_pkg::CDTRT_SRC_64:   src_tick = ticks.tick_64;    // [RQ13]
         cdtrt_pkg::CDTRT_SRC_SEC:  src_tick = ticks.tick_sec;   // [RQ13]
         cdtrt_pkg::CDTRT_SRC_MIN:  src_tick = minute_tick_in;   // [RQ13] [RQ17]
      endcase

      // down counter steps on source enables only while running and not halted;
      // a start between enables makes the first step early, so the interval
      // is preset periods or up to one period less
      if (s.tctrl[cdtrt_pkg::T_RUN] && !s.halt && src_tick && s.count != 8'h00) begin // [RQ2] [RQ15]
         if (s.count == 8'h01) begin
            event_hit = 1'b1; // [RQ14]
            if (s.tctrl[cdtrt_pkg::T_REPEAT]) begin
               next_s.count = s.preset; // [RQ9]
            end else begin
               next_s.count = 8'h00; // [RQ8]
               next_s.tctrl[cdtrt_pkg::T_RUN] = 1'b0; // [RQ8]
            end
         end else begin
            next_s.count = s.count - 8'h01;
         end
      end
      // a zero count never steps, so a zero preset raises no event [RQ12]

      // half-minute round request holds, then clears itself
      if (s.adj_cnt != '0) begin
         next_s.adj_cnt = s.adj_cnt - cdtrt_pkg::CNT_W'(1);
         if (s.adj_cnt == cdtrt_pkg::CNT_W'(1)) begin
            next_s.adj = 1'b0;
         end
      end

      // register writes; control E and F decode in every bank
      if (wr_evt) begin
         if (addr == cdtrt_pkg::ADDR_CTRL_E) begin // [RQ25]
            next_s.test       = d[cdtrt_pkg::E_TEST];
            next_s.temp       = d[cdtrt_pkg::E_TEMP];
            next_s.irq_enable = d[cdtrt_pkg::E_IRQ_EN];
            if (!d[cdtrt_pkg::E_FLAG]) begin
               next_s.flag = 1'b0; // [RQ1]
            end
         end else if (addr == cdtrt_pkg::ADDR_CTRL_F) begin // [RQ25]
            next_s.bank = d[cdtrt_pkg::F_BANK_LO +: 2];
            next_s.halt = d[cdtrt_pkg::F_HALT];
            // only a 1 starts a round; a 0 does not cancel it
            if (d[cdtrt_pkg::F_ADJ] && !s.adj) begin
               next_s.adj       = 1'b1;
               next_s.adj_cnt   = cdtrt_pkg::CNT_W'(ADJ_HOLD_CYC);
               next_s.round_req = 1'b1;
            end
         end else if (bank_eff == cdtrt_pkg::BANK_2) begin
            unique case (addr)
               cdtrt_pkg::ADDR_TRIM_LO: next_s.trim_lo = d; // [RQ23]
               cdtrt_pkg::ADDR_TRIM_HI: next_s.trim_hi = d; // [RQ20]
               cdtrt_pkg::ADDR_PRESET_LO: begin
                  next_s.preset[3:0] = d;
                  next_s.count       = {s.preset[7:4], d}; // [RQ11]
               end
               cdtrt_pkg::ADDR_PRESET_HI: begin
                  next_s.preset[7:4] = d;
                  next_s.count       = {d, s.preset[3:0]}; // [RQ11]
               end
               cdtrt_pkg::ADDR_TIMER_CTRL: next_s.tctrl = d; // [RQ2]
               default: ; // live count and unused addresses ignore writes [RQ10]
            endcase
         end else if (bank_eff == cdtrt_pkg::BANK_1 && addr == cdtrt_pkg::ADDR_CS1_CTRL) begin
            next_s.cs1_ctrl = d[cdtrt_pkg::C_TEMP -: 2]; // [RQ21]
         end
      end

      // the event sets the flag after the write, so a clear in the same cycle loses
      if (event_hit) begin
         next_s.flag = 1'b1; // [RQ1]
      end

      // repeat mode gives a fixed-width pulse whose width follows the source
      if (event_hit && s.irq_enable && s.tctrl[cdtrt_pkg::T_REPEAT]) begin // [RQ5]
         if (s.tctrl[cdtrt_pkg::T_SEL_LO +: 2] == cdtrt_pkg::CDTRT_SRC_4096) begin
            next_s.pulse_cnt = cdtrt_pkg::CNT_W'(PULSE_FAST_CYC); // [RQ6]
         end else begin
            next_s.pulse_cnt = cdtrt_pkg::CNT_W'(PULSE_SLOW_CYC); // [RQ6]
         end
      end else if (s.pulse_cnt != '0) begin
         next_s.pulse_cnt = s.pulse_cnt - cdtrt_pkg::CNT_W'(1);
      end

      // level mode holds the pin while the flag stands; without the enable the
      // timer never pulls the pin
      timer_drive = next_s.irq_enable
                    & ((next_s.flag & ~next_s.tctrl[cdtrt_pkg::T_REPEAT])  // [RQ3] [RQ4]
                       | (next_s.pulse_cnt != '0));                        // [RQ5]
      // either source pulls the shared pin, whatever the other's enable
      next_s.irq_oe = timer_drive | alarm_irq_req_in; // [RQ7]
      next_s.irq_n  = ~next_s.irq_oe;

      // read mux
      if (addr == cdtrt_pkg::ADDR_CTRL_E) begin
         rdata = {s.test, s.temp, s.irq_enable, s.flag};
      end else if (addr == cdtrt_pkg::ADDR_CTRL_F) begin
         rdata = {s.bank, s.halt, s.adj};
      end else if (bank_eff == cdtrt_pkg::BANK_2) begin
         unique case (addr)
            cdtrt_pkg::ADDR_TRIM_LO:    rdata = s.trim_lo;
            cdtrt_pkg::ADDR_TRIM_HI:    rdata = s.trim_hi;
            cdtrt_pkg::ADDR_PRESET_LO:  rdata = s.preset[3:0];
            cdtrt_pkg::ADDR_PRESET_HI:  rdata = s.preset[7:4];
            cdtrt_pkg::ADDR_LIVE_LO:    rdata = s.count[3:0]; // [RQ10]
            cdtrt_pkg::ADDR_LIVE_HI:    rdata = s.count[7:4]; // [RQ10]
            cdtrt_pkg::ADDR_TIMER_CTRL: rdata = s.tctrl;
            default:                    rdata = 4'h0;
         endcase
      end else if (bank_eff == cdtrt_pkg::BANK_1 && addr == cdtrt_pkg::ADDR_CS1_CTRL) begin
         rdata = {s.cs1_ctrl, 2'h0};
      end
      // data is driven for as long as the read strobe is seen low
      next_s.data_oe  = rd_act;
      next_s.data_out = rd_act ? rdata : 4'h0;
   end

   // state register; the pin idles released
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s          <= '0;
         s.bus_s1   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 4'h0};
         s.bus_s2   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 4'h0};
         s.wr_n_prev <= 1'b1;
         s.preset   <= cdtrt_pkg::RST_BYTE;
         s.trim_lo  <= cdtrt_pkg::RST_NIBBLE;
         s.trim_hi  <= cdtrt_pkg::RST_NIBBLE;
         s.tctrl    <= cdtrt_pkg::RST_NIBBLE;
         s.irq_n    <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flops
   assign bus_data_out          = s.data_out;
   assign bus_data_oe_out       = s.data_oe;
   assign irq_n_out             = s.irq_n;
   assign irq_oe_out            = s.irq_oe;
   assign second_tick_out       = s.sec_tick;
   assign half_minute_round_out = s.round_req;
   assign halt_out              = s.halt;

endmodule

// ---- tb/cdtrt_checker.sv ----
`timescale 1ns/1ps
// port-level checks of the countdown block; pin timing assumes the 2-flop syncs
module cdtrt_checker (
   // clock and reset
   input wire logic            clk_in,
   input wire logic            rst_in,
   // bus
   input cdtrt_pkg::cdtrt_bus_s bus_in,
   input wire logic [3:0]      bus_data_out,
   input wire logic            bus_data_oe_out,
   // side inputs
   input wire logic            chip_select_one_pin_in,
   input wire logic            alarm_irq_req_in,
   input wire logic            minute_tick_in,
   // outputs
   input wire logic            irq_n_out,
   input wire logic            irq_oe_out,
   input wire logic            second_tick_out,
   input wire logic            half_minute_round_out,
   input wire logic            halt_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // open drain: level low exactly while pulled
   irq_pin_a: assert property (irq_n_out == !irq_oe_out)
      else $error("irq level and drive disagree");
   alarm_pin_a: assert property (alarm_irq_req_in |=> irq_oe_out)
      else $error("alarm request did not pull irq");
   alarm_hold_a: assert property ($fell(irq_oe_out) |-> !$past(alarm_irq_req_in))
      else $error("irq released under alarm request");
   // data driven only three clocks after a selected read strobe
   read_drive_a: assert property (bus_data_oe_out |-> $past(!bus_in.cs_n && !bus_in.rd_n, 3))
      else $error("data driven without read strobe");
   data_idle_a: assert property (!bus_data_oe_out |-> bus_data_out == 4'h0)
      else $error("data not zero while idle");
   adj_pulse_a: assert property (half_minute_round_out |=> !half_minute_round_out)
      else $error("round pulse longer than a cycle");
   adj_write_a: assert property ($rose(half_minute_round_out) |-> $past(!bus_in.cs_n && bus_in.addr == 4'hF, 2))
      else $error("round pulse without control write");
   halt_write_a: assert property ($changed(halt_out) |-> $past(!bus_in.cs_n && bus_in.addr == 4'hF, 2))
      else $error("halt moved without control write");
endmodule

// ---- tb/cdtrt_host.sv ----
`timescale 1ns/1ps
// host processor on the nibble bus; write strobes last 4 clocks and read strobes 5, so the syncs catch them
module cdtrt_host (
   // clock
   input  wire logic            clk_in,
   // device read drive
   input  wire logic [3:0]      dev_data_in,
   input  wire logic            dev_oe_in,
   // bus pins
   output cdtrt_pkg::cdtrt_bus_s bus_out
);
   logic       cs_n = 1'b1; // idle high
   logic       rd_n = 1'b1;
   logic       wr_n = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [3:0] dat  = 4'h0; // host drive of data lines
   // wire level: device nibble while it drives, else host nibble
   assign bus_out = {cs_n, rd_n, wr_n, addr, dev_oe_in ? dev_data_in : dat};
   // wait edges, then step off the edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // write; the device takes the write on the rise of the strobe
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      hold(1);
      cs_n = 1'b0;
      addr = a;
      dat  = d;
      wr_n = 1'b0;
      hold(4);
      wr_n = 1'b1;
      hold(4);
      cs_n = 1'b1;
      dat  = ~d; // released data no longer shows the value
      hold(4);
   endtask
   // read one nibble once the device has driven it
   task automatic rd(input logic [3:0] a, output logic [3:0] q);
      hold(1);
      cs_n = 1'b0;
      addr = a;
      rd_n = 1'b0;
      hold(5);
      q    = bus_out.data;
      cs_n = 1'b1;
      rd_n = 1'b1;
      hold(4);
   endtask
endmodule

// ---- tb/cdtrt_bench.sv ----
`timescale 1ns/1ps
module cdtrt_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cs1 = 1'b0;
   logic alarm = 1'b0;
   logic minute = 1'b0;
   logic [3:0] dq, q;
   logic doe, irq_oe, irq_n, halt, round;
   cdtrt_pkg::cdtrt_bus_s bus;
   int n_fail = 0;
   int checked = 0;
   int rounds = 0; // round pulses seen
   // short pulse widths keep the run brief; crystal count is 8 clocks
   cdtrt_host HOST (.clk_in(clk_in), .dev_data_in(dq), .dev_oe_in(doe), .bus_out(bus));
   cdtrt_top #(.CLK_HZ(262144), .PULSE_FAST_CYC(8), .PULSE_SLOW_CYC(20), .ADJ_HOLD_CYC(5)) DUT (
      .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .bus_data_out(dq), .bus_data_oe_out(doe),
      .chip_select_one_pin_in(cs1), .alarm_irq_req_in(alarm), .minute_tick_in(minute),
      .irq_n_out(irq_n), .irq_oe_out(irq_oe), .second_tick_out(), .half_minute_round_out(round), .halt_out(halt));
   initial forever #5 clk_in = ~clk_in;
   // the round pulse lasts one cycle, too short for the tasks to sample
   always @(posedge clk_in) begin
      if (round) rounds++;
   end
   task automatic results;
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [3:0] exp);
      HOST.rd(a, q);
      chk({4'h0, q}, {4'h0, exp});
   endtask
   // level mode: flag, held pin, self stop at zero
   task automatic t_level;
      HOST.wr(4'hE, 4'h2);
      HOST.wr(4'h4, 4'h3);
      HOST.wr(4'h5, 4'h0);
      rdc(4'h6, 4'h3);
      HOST.wr(4'h6, 4'hF);
      rdc(4'h6, 4'h3);
      HOST.wr(4'h8, 4'h8);
      HOST.hold(300);
      chk(irq_oe, 1'b1);
      chk(irq_n, 1'b0);
      rdc(4'hE, 4'h3);
      rdc(4'h8, 4'h0);
      rdc(4'h6, 4'h0);
      HOST.wr(4'hE, 4'h3);
      chk(irq_oe, 1'b1);
      HOST.wr(4'hE, 4'h2);
      chk(irq_oe, 1'b0);
      chk(irq_n, 1'b1);
   endtask
   // repeat mode: pulse width follows the source, timer reloads and keeps running
   task automatic t_repeat(input logic [3:0] ctl, input int w);
      int n;
      HOST.wr(4'h4, 4'h1);
      HOST.wr(4'h8, ctl);
      for (n = 0; n < 5000 && irq_oe !== 1'b1; n++) HOST.hold(1);
      for (n = 0; n < 50 && irq_oe === 1'b1; n++) HOST.hold(1);
      chk(n, w);
      rdc(4'h8, ctl);
      rdc(4'h6, 4'h1);
      rdc(4'hE, 4'h3);
      HOST.wr(4'h8, 4'h0);
      HOST.wr(4'hE, 4'h2);
   endtask
   // enable off: pin quiet, flag polled; then a zero preset
   task automatic t_quiet;
      HOST.wr(4'hE, 4'h0);
      HOST.wr(4'h8, 4'hC);
      HOST.hold(300);
      chk(irq_oe, 1'b0);
      rdc(4'hE, 4'h1);
      HOST.wr(4'h8, 4'h0);
      HOST.wr(4'hE, 4'h2);
      HOST.wr(4'h4, 4'h0);
      HOST.wr(4'h8, 4'h8);
      HOST.hold(300);
      chk(irq_oe, 1'b0);
      rdc(4'hE, 4'h2);
   endtask
   task automatic tick;
      minute = 1'b1;
      HOST.hold(1);
      minute = 1'b0;
      HOST.hold(3);
   endtask
   // minute source steps only on the carry and only while running
   task automatic t_minute;
      HOST.wr(4'h4, 4'h5);
      HOST.wr(4'h8, 4'hB);
      tick();
      tick();
      rdc(4'h6, 4'h3);
      HOST.wr(4'h8, 4'h3);
      HOST.wr(4'hE, 4'h0);
      tick();
      rdc(4'h6, 4'h3);
   endtask
   // shared pin, banks and the common control registers
   task automatic t_misc;
      alarm = 1'b1;
      HOST.hold(3);
      chk(irq_oe, 1'b1);
      alarm = 1'b0;
      HOST.hold(3);
      chk(irq_oe, 1'b0);
      HOST.wr(4'hF, 4'hC);
      rdc(4'h4, 4'h0);
      rdc(4'hE, 4'h0);
      HOST.wr(4'hF, 4'h2);
      chk(halt, 1'b1);
      rdc(4'hF, 4'h2);
      HOST.wr(4'hF, 4'h1);
      chk(rounds, 1);
      rdc(4'hF, 4'h0);
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      #1 rst_in = 1'b0;
      cs1 = 1'b1;
      HOST.wr(4'hF, 4'h8);
      HOST.wr(4'h1, 4'h0);
      t_level();
      t_repeat(4'hC, 8);
      t_repeat(4'hD, 20);
      t_quiet();
      t_minute();
      t_misc();
      results();
   end
   initial begin
      #200000;
      n_fail++;
      results();
   end
endmodule
bind cdtrt_top cdtrt_checker u_chk (.clk_in, .rst_in, .bus_in, .bus_data_out, .bus_data_oe_out,
   .chip_select_one_pin_in, .alarm_irq_req_in, .minute_tick_in, .irq_n_out, .irq_oe_out,
   .second_tick_out, .half_minute_round_out, .halt_out);
